//--- hdl/sysctl_pkg.sv
// constants and reset tables for the system-control register bank
package sysctl_pkg;

  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int NUM_IDX = 64;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PROC_MODE_0 = 6'h04;
  localparam logic [5:0] IDX_PROC_MODE_1 = 6'h05;
  localparam logic [5:0] IDX_SYS_CLK_0 = 6'h06;
  localparam logic [5:0] IDX_SYS_CLK_1 = 6'h07;
  localparam logic [5:0] IDX_WRITE_PROTECT = 6'h0A;
  localparam logic [5:0] IDX_OSC_STOP = 6'h0C;
  localparam logic [5:0] IDX_WDOG_REFRESH = 6'h0D;
  localparam logic [5:0] IDX_WDOG_START = 6'h0E;
  localparam logic [5:0] IDX_WDOG_CONTROL = 6'h0F;
  localparam logic [5:0] IDX_ADDR_MATCH_0 = 6'h10;
  localparam logic [5:0] IDX_ADDR_MATCH_EN = 6'h13;
  localparam logic [5:0] IDX_ADDR_MATCH_1 = 6'h14;
  localparam logic [5:0] IDX_CSP = 6'h1C;
  localparam logic [5:0] IDX_FOSC_CTRL_0 = 6'h23;
  localparam logic [5:0] IDX_FOSC_TRIM = 6'h24;
  localparam logic [5:0] IDX_FOSC_CTRL_2 = 6'h25;
  localparam logic [5:0] IDX_VDET_1 = 6'h31;
  localparam logic [5:0] IDX_VDET_2 = 6'h32;
  localparam logic [5:0] IDX_VMON_1 = 6'h36;
  localparam logic [5:0] IDX_VMON_2 = 6'h37;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SYS_CLK_0 = 8'h68;
  localparam logic [7:0] RST_SYS_CLK_1 = 8'h20;
  localparam logic [7:0] RST_OSC_STOP = 8'h04;
  localparam logic [7:0] RST_WDOG_CONTROL = 8'h1F;
  localparam logic [7:0] RST_CSP_OPT_CLR = 8'h80;
  localparam logic [7:0] RST_VDET_1 = 8'h08;
  localparam logic [7:0] RST_VDET_2_ON = 8'h40;
  localparam logic [7:0] RST_VMON_1_ON = 8'h41;

  // bits held through software, watchdog and monitor-2 resets
  localparam logic [7:0] KEEP_VDET_1 = 8'hFF;
  localparam logic [7:0] KEEP_VDET_2 = 8'h80;
  localparam logic [7:0] KEEP_VMON_1 = 8'hBE;
  localparam logic [7:0] KEEP_VMON_2 = 8'h0C;

  function automatic logic is_stored(input logic [5:0] idx);
    case (idx)
      IDX_PROC_MODE_0, IDX_PROC_MODE_1, IDX_SYS_CLK_0, IDX_SYS_CLK_1,
      IDX_WRITE_PROTECT, IDX_OSC_STOP, IDX_WDOG_CONTROL,
      IDX_ADDR_MATCH_0, IDX_ADDR_MATCH_0 + 6'h01, IDX_ADDR_MATCH_0 + 6'h02,
      IDX_ADDR_MATCH_EN,
      IDX_ADDR_MATCH_1, IDX_ADDR_MATCH_1 + 6'h01, IDX_ADDR_MATCH_1 + 6'h02,
      IDX_CSP, IDX_FOSC_CTRL_0, IDX_FOSC_TRIM, IDX_FOSC_CTRL_2,
      IDX_VDET_1, IDX_VDET_2, IDX_VMON_1, IDX_VMON_2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // value after a reset; full marks power-on or monitor-1 reset
  function automatic logic [7:0] rst_val(input logic [5:0] idx, input logic lvd_opt,
                                         input logic csp_opt, input logic full,
                                         input logic [7:0] trim);
    case (idx)
      IDX_SYS_CLK_0: return RST_SYS_CLK_0;
      IDX_SYS_CLK_1: return RST_SYS_CLK_1;
      IDX_OSC_STOP: return RST_OSC_STOP;
      IDX_WDOG_CONTROL: return RST_WDOG_CONTROL;
      IDX_CSP: return csp_opt ? RST_ZERO : RST_CSP_OPT_CLR;
      IDX_FOSC_TRIM: return trim;
      IDX_VDET_1: return RST_VDET_1;
      IDX_VDET_2: return (full || !lvd_opt) ? RST_VDET_2_ON : RST_ZERO;
      IDX_VMON_1: return (full || !lvd_opt) ? RST_VMON_1_ON : RST_ZERO;
      default: return RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] keep_mask(input logic [5:0] idx);
    case (idx)
      IDX_VDET_1: return KEEP_VDET_1;
      IDX_VDET_2: return KEEP_VDET_2;
      IDX_VMON_1: return KEEP_VMON_1;
      IDX_VMON_2: return KEEP_VMON_2;
      default: return RST_ZERO;
    endcase
  endfunction

endpackage

//--- hdl/system_control_register_bank.sv
// system-control register bank behind an APB slave
`timescale 1ns/100ps
module system_control_register_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sysctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_reset,
  input wire logic wdt_reset,
  input wire logic vm1_reset,
  input wire logic vm2_reset,
  input wire logic low_voltage_detect_option,
  input wire logic count_source_protect_initial,
  input wire logic [7:0] fast_osc_trim_factory,
  output logic [7:0] processor_mode_0,
  output logic [7:0] processor_mode_1,
  output logic [7:0] system_clock_control_0,
  output logic [7:0] system_clock_control_1,
  output logic [7:0] write_protect,
  output logic [7:0] oscillation_stop_detect,
  output logic [7:0] watchdog_control,
  output logic [23:0] address_match_0,
  output logic [7:0] address_match_enable,
  output logic [23:0] address_match_1,
  output logic [7:0] count_source_protect,
  output logic [7:0] fast_osc_control_0,
  output logic [7:0] fast_osc_trim,
  output logic [7:0] fast_osc_control_2,
  output logic [7:0] voltage_detect_1,
  output logic [7:0] voltage_detect_2,
  output logic [7:0] volt_monitor_1_control,
  output logic [7:0] volt_monitor_2_control,
  output logic watchdog_refresh_pulse,
  output logic watchdog_start_pulse
);

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic init_r;
  wire logic full_rst;
  wire logic part_rst;

  // options are only valid once the async reset is gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_r <= 1'b1;
    end else if (ce) begin
      init_r <= 1'b0;
    end
  end

  assign full_rst = init_r | vm1_reset;
  assign part_rst = sw_reset | wdt_reset | vm2_reset;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic ready_r;
  logic err_r;
  logic [31:0] prdata_r;
  logic wd_refresh_r;
  logic wd_start_r;
  wire logic [sysctl_pkg::IDX_W-1:0] idx;
  wire logic stored_hit;
  wire logic wo_hit;
  wire logic mapped_hit;
  wire logic xfer_done;
  wire logic wr_en;
  wire logic [7:0] rd_byte;
  logic [7:0] reg_q [sysctl_pkg::NUM_IDX];

  assign idx = paddr[sysctl_pkg::ADDR_W-1:2];
  assign stored_hit = sysctl_pkg::is_stored(idx);
  assign wo_hit = (idx == sysctl_pkg::IDX_WDOG_REFRESH) ||
                  (idx == sysctl_pkg::IDX_WDOG_START);
  assign mapped_hit = stored_hit | wo_hit;
  assign xfer_done = psel & penable & ready_r & ce;
  assign wr_en = xfer_done & pwrite & pstrb[0] & mapped_hit & ~err_r;
  assign rd_byte = stored_hit ? reg_q[idx] : 8'h00;
  assign pready = penable & ready_r & ce;
  assign pslverr = err_r;
  assign prdata = prdata_r;

  // data and error are captured ahead of the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
      err_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      ready_r <= psel & ~(penable & ready_r);
      if (psel && !ready_r) begin
        err_r <= ~mapped_hit;
        prdata_r <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog write-only strobes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_refresh_r <= 1'b0;
      wd_start_r <= 1'b0;
    end else if (ce) begin
      wd_refresh_r <= wr_en && (idx == sysctl_pkg::IDX_WDOG_REFRESH);
      wd_start_r <= wr_en && (idx == sysctl_pkg::IDX_WDOG_START);
    end
  end

  assign watchdog_refresh_pulse = wd_refresh_r;
  assign watchdog_start_pulse = wd_start_r;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  for (genvar i = 0; i < sysctl_pkg::NUM_IDX; i++) begin : g_reg
    localparam logic [5:0] I = 6'(i);
    if (sysctl_pkg::is_stored(I)) begin : g_stored
      localparam logic [7:0] POR_VAL = sysctl_pkg::rst_val(I, 1'b0, 1'b1, 1'b1, 8'h00);
      localparam logic [7:0] KEEP = sysctl_pkg::keep_mask(I);
      logic [7:0] val_r;
      wire logic [7:0] full_val;
      wire logic [7:0] part_val;
      wire logic [7:0] val_nxt;

      assign full_val = sysctl_pkg::rst_val(I, low_voltage_detect_option,
                                            count_source_protect_initial, 1'b1,
                                            fast_osc_trim_factory);
      assign part_val = (val_r & KEEP) |
                        (sysctl_pkg::rst_val(I, low_voltage_detect_option,
                                             count_source_protect_initial, 1'b0,
                                             fast_osc_trim_factory) & ~KEEP);
      assign val_nxt = full_rst ? full_val :
                       part_rst ? part_val :
                       (wr_en && idx == I) ? pwdata[7:0] : val_r;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_r <= POR_VAL;
        end else if (ce) begin
          val_r <= val_nxt;
        end
      end

      assign reg_q[i] = val_r;
    end else begin : g_empty
      assign reg_q[i] = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // register outputs
  // ----------------------------------------------------------------
  assign processor_mode_0 = reg_q[sysctl_pkg::IDX_PROC_MODE_0];
  assign processor_mode_1 = reg_q[sysctl_pkg::IDX_PROC_MODE_1];
  assign system_clock_control_0 = reg_q[sysctl_pkg::IDX_SYS_CLK_0];
  assign system_clock_control_1 = reg_q[sysctl_pkg::IDX_SYS_CLK_1];
  assign write_protect = reg_q[sysctl_pkg::IDX_WRITE_PROTECT];
  assign oscillation_stop_detect = reg_q[sysctl_pkg::IDX_OSC_STOP];
  assign watchdog_control = reg_q[sysctl_pkg::IDX_WDOG_CONTROL];
  assign address_match_0 = {reg_q[sysctl_pkg::IDX_ADDR_MATCH_0 + 6'h02],
                            reg_q[sysctl_pkg::IDX_ADDR_MATCH_0 + 6'h01],
                            reg_q[sysctl_pkg::IDX_ADDR_MATCH_0]};
  assign address_match_enable = reg_q[sysctl_pkg::IDX_ADDR_MATCH_EN];
  assign address_match_1 = {reg_q[sysctl_pkg::IDX_ADDR_MATCH_1 + 6'h02],
                            reg_q[sysctl_pkg::IDX_ADDR_MATCH_1 + 6'h01],
                            reg_q[sysctl_pkg::IDX_ADDR_MATCH_1]};
  assign count_source_protect = reg_q[sysctl_pkg::IDX_CSP];
  assign fast_osc_control_0 = reg_q[sysctl_pkg::IDX_FOSC_CTRL_0];
  assign fast_osc_trim = reg_q[sysctl_pkg::IDX_FOSC_TRIM];
  assign fast_osc_control_2 = reg_q[sysctl_pkg::IDX_FOSC_CTRL_2];
  assign voltage_detect_1 = reg_q[sysctl_pkg::IDX_VDET_1];
  assign voltage_detect_2 = reg_q[sysctl_pkg::IDX_VDET_2];
  assign volt_monitor_1_control = reg_q[sysctl_pkg::IDX_VMON_1];
  assign volt_monitor_2_control = reg_q[sysctl_pkg::IDX_VMON_2];

endmodule // system_control_register_bank

//--- testbench/sysctl_asserts.sv
// concurrent checks for the system-control register bank
`timescale 1ns/100ps
module sysctl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sysctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sw_reset,
  input wire logic wdt_reset,
  input wire logic vm1_reset,
  input wire logic vm2_reset,
  input wire logic low_voltage_detect_option,
  input wire logic count_source_protect_initial,
  input wire logic [7:0] system_clock_control_0,
  input wire logic [7:0] system_clock_control_1,
  input wire logic [7:0] oscillation_stop_detect,
  input wire logic [7:0] watchdog_control,
  input wire logic [7:0] count_source_protect,
  input wire logic [7:0] voltage_detect_1,
  input wire logic [7:0] voltage_detect_2,
  input wire logic [7:0] volt_monitor_1_control,
  input wire logic [7:0] volt_monitor_2_control
);
  // ----------------------------------------
  // reset and transfer qualifiers
  // ----------------------------------------
  // the first enabled edge after release is itself a full reset
  logic run_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else if (ce) begin
      run_r <= 1'b1;
    end
  end
  wire part = run_r && ce && !vm1_reset && (sw_reset || wdt_reset || vm2_reset);
  wire anyr = ce && (vm1_reset || sw_reset || wdt_reset || vm2_reset);
  wire done = psel && penable && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unmapped_err: assert property (done && !pwrite && paddr[7:2] == 6'h08 |->
    pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  a_vdet1_kept: assert property (part |=> $stable(voltage_detect_1))
    else $error("voltage detect 1 lost on partial reset");
  a_vdet2_part: assert property (part |=> voltage_detect_2 == (($past(voltage_detect_2)
    & 8'h80) | ($past(low_voltage_detect_option) ? 8'h00 : 8'h40))) else $error("vdet2 bad");
  a_vmon2_part: assert property (part |=> volt_monitor_2_control ==
    ($past(volt_monitor_2_control) & 8'h0C)) else $error("monitor 2 control bad");
  a_vmon1_part: assert property (part |=> (volt_monitor_1_control & 8'hBE) ==
    ($past(volt_monitor_1_control) & 8'hBE) && {volt_monitor_1_control[6],
    volt_monitor_1_control[0]} == {2{!$past(low_voltage_detect_option)}})
    else $error("monitor 1 control bad");
  a_full_vdet: assert property (ce && vm1_reset |=> voltage_detect_2 == 8'h40 &&
    volt_monitor_1_control == 8'h41 && voltage_detect_1 == 8'h08) else $error("full reset bad");
  a_csp_reset: assert property (anyr |=> count_source_protect ==
    ($past(count_source_protect_initial) ? 8'h00 : 8'h80)) else $error("csp reset bad");
  a_clock_reset: assert property (anyr |=> system_clock_control_0 == 8'h68 &&
    system_clock_control_1 == 8'h20 && oscillation_stop_detect == 8'h04)
    else $error("clock reset values bad");
  a_wdog_reset: assert property (anyr |=> watchdog_control == 8'h1F)
    else $error("watchdog control reset bad");
  cover property (part);
  cover property (ce && vm1_reset);
  cover property (done && pslverr);
endmodule // sysctl_asserts

bind system_control_register_bank sysctl_asserts i_sysctl_asserts (.*);

//--- testbench/system_control_register_bank_tb.sv
// self-checking bench for the system-control register bank
`timescale 1ns/100ps
module system_control_register_bank_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] rq = 4'h0;
  logic lvd = 1'b0;
  logic cspi = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic er;
  logic [7:0] mode0_q;
  logic [23:0] am0;
  logic [23:0] am1;
  logic wd_ref;
  logic wd_start;
  logic ce = 1'b1;
  int n_ref = 0;
  int n_start = 0;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  // index and full-reset value with both options clear
  logic [13:0] tbl [24] = '{14'h0400, 14'h0500, 14'h0668, 14'h0720, 14'h0A00, 14'h0C04,
    14'h0D00, 14'h0E00, 14'h0F1F, 14'h1000, 14'h1100, 14'h1200, 14'h1300, 14'h1400,
    14'h1500, 14'h1600, 14'h1C80, 14'h2300, 14'h245A, 14'h2500, 14'h3108, 14'h3240,
    14'h3641, 14'h3700};
  always #2.5 pclk = ~pclk;
  system_control_register_bank i_system_control_register_bank (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sw_reset(rq[0]), .wdt_reset(rq[1]),
    .vm2_reset(rq[2]), .vm1_reset(rq[3]), .low_voltage_detect_option(lvd),
    .count_source_protect_initial(cspi), .fast_osc_trim_factory(8'h5A),
    .processor_mode_0(mode0_q), .processor_mode_1(), .system_clock_control_0(),
    .system_clock_control_1(), .write_protect(), .oscillation_stop_detect(),
    .watchdog_control(), .address_match_0(am0), .address_match_enable(),
    .address_match_1(am1),
    .count_source_protect(), .fast_osc_control_0(), .fast_osc_trim(),
    .fast_osc_control_2(), .voltage_detect_1(), .voltage_detect_2(),
    .volt_monitor_1_control(), .volt_monitor_2_control(), .watchdog_refresh_pulse(wd_ref),
    .watchdog_start_pulse(wd_start));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // full marks power-on or monitor-1 reset; others start from all ones
  task automatic check_bank(input logic full);
    logic [7:0] e;
    for (int i = 0; i < 24; i++) begin
      e = tbl[i][7:0];
      case (tbl[i][13:8])
        6'h1C: e = cspi ? 8'h00 : 8'h80;
        6'h31: e = full ? 8'h08 : 8'hFF;
        6'h32: e = full ? 8'h40 : (lvd ? 8'h80 : 8'hC0);
        6'h36: e = full ? 8'h41 : (lvd ? 8'hBE : 8'hFF);
        6'h37: e = full ? 8'h00 : 8'h0C;
        default: ;
      endcase
      apb(1'b0, tbl[i][13:8], 8'h00, 4'hF);
      chk($sformatf("reg %h", tbl[i][13:8]), {24'h0, e}, rd);
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wd_ref === 1'b1) n_ref <= n_ref + 1;
    if (wd_start === 1'b1) n_start <= n_start + 1;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [5:0] ix;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check_bank(1'b1);
    for (int i = 0; i < 24; i++) begin
      ix = tbl[i][13:8];
      apb(1'b1, ix, {2'b10, ix}, 4'hF);
      apb(1'b0, ix, 8'h00, 4'hF);
      chk("readback", (ix == 6'h0D || ix == 6'h0E) ? 32'h0 : {24'h0, 2'b10, ix}, rd);
    end
    chk("match 0", 32'h0092_9190, {8'h00, am0});
    chk("match 1", 32'h0096_9594, {8'h00, am1});
    chk("refresh pulses", 32'h1, n_ref);
    chk("start pulses", 32'h1, n_start);
    apb(1'b1, 6'h04, 8'h55, 4'h0);
    apb(1'b0, 6'h04, 8'h00, 4'hF);
    chk("strobe off", 32'h84, rd);
    chk("mode 0 port", 32'h84, {24'h0, mode0_q});
    // clock enable low stalls the access phase
    ce <= 1'b0;
    fork
      apb(1'b0, 6'h04, 8'h00, 4'hF);
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk("stalled read", 32'h84, rd);
    apb(1'b1, 6'h08, 8'h3C, 4'hF);
    chk("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, 6'h08, 8'h00, 4'hF);
    chk("unmapped read err", 32'h1, {31'h0, er});
    chk("unmapped read data", 32'h0, rd);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 24; i++) apb(1'b1, tbl[i][13:8], 8'hFF, 4'hF);
      lvd <= ~k[0];
      cspi <= k[0];
      @(posedge pclk);
      rq <= 4'h1 << k;
      @(posedge pclk);
      rq <= 4'h0;
      check_bank(k == 3);
    end
    chk("refresh total", 32'h5, n_ref);
    chk("start total", 32'h5, n_start);
    report_and_stop();
  end
endmodule // system_control_register_bank_tb
